// ===== rtl/irc_modulator.sv
// Infrared carrier generator, modulator and output stage with AHB-Lite registers
`timescale 1ns/1ps
`include "irc_cfg.svh"

module irc_modulator #(
    parameter int COUNT_W = 6,
    parameter int MOD_W   = 12
) (
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // AHB-Lite slave
    input  wire logic              HSEL,
    input  wire irc_pkg::irc_addr_t HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire irc_pkg::irc_word_t HWDATA,
    input  wire logic              HREADY,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    output irc_pkg::irc_word_t     HRDATA,
    // Infrared output
    output logic                   IR_OUT
);
    import irc_pkg::*;

    if (COUNT_W != 6 || MOD_W != 12) begin : g_bad_width
        $error("irc_modulator: register layout needs COUNT_W 6 and MOD_W 12");
    end

    localparam int UNIT_CLKS = `IRC_TIME_UNIT;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    logic               wr_pend_reg;
    logic [7:0]         wr_addr_reg;
    logic               rd_ctrl_reg;
    irc_word_t          rdata_reg;
    logic               ready_reg;

    logic [COUNT_W-1:0] pht_reg, plt_reg, sht_reg, slt_reg;
    logic [7:0]         ctrl_reg;
    logic [MOD_W-1:0]   mark_buf_reg, space_buf_reg;
    logic               latch_reg;
    logic               pend_fall_reg, pend_rise_reg, pend_val_reg;
    logic               proc_clk_reg;
    logic               eoc_reg;
    logic               eoc_armed_reg;

    wire       addr_ok  = HSEL && HREADY && HTRANS[1];
    wire       rd_req   = addr_ok && !HWRITE;
    wire [7:0] a_addr   = HADDR[7:0];
    wire [7:0] wdat     = HWDATA[7:0];
    wire       wr_pht   = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_PHT);
    wire       wr_plt   = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_PLT);
    wire       wr_sht   = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_SHT);
    wire       wr_slt   = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_SLT);
    wire       wr_ctrl  = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_CTRL);
    wire       wr_per1  = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_PER1);
    wire       wr_per2  = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_PER2);
    wire       wr_per3  = wr_pend_reg && hit(wr_addr_reg, `IRC_OFF_PER3);
    wire       acc_per23 = (addr_ok && (hit(a_addr, `IRC_OFF_PER2)
                                        || hit(a_addr, `IRC_OFF_PER3)));

    wire [7:0] ctrl_rd = {eoc_reg, ctrl_reg[6:0]};
    wire [7:0] rd_mux =
        hit(a_addr, `IRC_OFF_PHT)  ? {latch_reg, 1'b0, pht_reg} :
        hit(a_addr, `IRC_OFF_PLT)  ? {latch_reg, 1'b0, plt_reg} :
        hit(a_addr, `IRC_OFF_SHT)  ? {2'b00, sht_reg} :
        hit(a_addr, `IRC_OFF_SLT)  ? {2'b00, slt_reg} :
        hit(a_addr, `IRC_OFF_CTRL) ? ctrl_rd :
        hit(a_addr, `IRC_OFF_PER1) ? {mark_buf_reg[11:8], space_buf_reg[11:8]} :
        hit(a_addr, `IRC_OFF_PER2) ? mark_buf_reg[7:0] :
        hit(a_addr, `IRC_OFF_PER3) ? space_buf_reg[7:0] : 8'h00;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
            ready_reg   <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && HWRITE;
            wr_addr_reg <= a_addr;
            rdata_reg   <= rd_req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            ready_reg   <= 1'b1;
        end
    end

    assign HREADYOUT = ready_reg;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_reg;

    // ------------------------------------------------------------------------
    // Control and data registers
    // ------------------------------------------------------------------------
    wire en   = ctrl_reg[`IRC_EN_BIT];
    wire fsk  = ctrl_reg[`IRC_MODE_BIT];
    wire baseband_select = ctrl_reg[`IRC_BASEBAND_SELECT_BIT];
    wire clock_halve = ctrl_reg[`IRC_CLOCK_HALVE_BIT];

    // Counts reset to one so an early enable cannot stall on a zero compare
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pht_reg       <= `IRC_COUNT_RST;
            plt_reg       <= `IRC_COUNT_RST;
            sht_reg       <= `IRC_COUNT_RST;
            slt_reg       <= `IRC_COUNT_RST;
            ctrl_reg      <= `IRC_CTRL_RST;
            mark_buf_reg  <= `IRC_PERIOD_RST;
            space_buf_reg <= `IRC_PERIOD_RST;
        end else begin
            if (wr_pht) pht_reg <= wdat[COUNT_W-1:0];
            if (wr_plt) plt_reg <= wdat[COUNT_W-1:0];
            if (wr_sht) sht_reg <= wdat[COUNT_W-1:0];
            if (wr_slt) slt_reg <= wdat[COUNT_W-1:0];
            if (wr_ctrl) ctrl_reg <= {1'b0, wdat[6:0]};
            if (wr_per1) begin
                mark_buf_reg[11:8]  <= wdat[7:4];
                space_buf_reg[11:8] <= wdat[3:0];
            end
            if (wr_per2) mark_buf_reg[7:0]  <= wdat;
            if (wr_per3) space_buf_reg[7:0] <= wdat;
        end
    end

    // ------------------------------------------------------------------------
    // Output latch
    // ------------------------------------------------------------------------
    // Processor clock is half the oscillator; level 1 means its falling edge is next
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            proc_clk_reg  <= 1'b0;
            latch_reg     <= 1'b0;
            pend_fall_reg <= 1'b0;
            pend_rise_reg <= 1'b0;
            pend_val_reg  <= 1'b0;
        end else begin
            proc_clk_reg <= !proc_clk_reg;
            if (wr_pht || wr_plt) begin
                pend_val_reg  <= wdat[`IRC_LATCH_BIT];
                pend_fall_reg <= wr_pht;
                pend_rise_reg <= wr_plt;
            end else if (pend_fall_reg && proc_clk_reg) begin
                latch_reg     <= pend_val_reg;
                pend_fall_reg <= 1'b0;
            end else if (pend_rise_reg && !proc_clk_reg) begin
                latch_reg     <= pend_val_reg;
                pend_rise_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Carrier generator
    // ------------------------------------------------------------------------
    logic [COUNT_W-1:0] car_cnt_reg;
    logic               car_high_sel_reg;
    logic               car_reg;
    logic               pair_sec_reg;
    logic               car_restart;

    wire tick    = clock_halve ? proc_clk_reg : 1'b1;
    wire car_run = en && !baseband_select;
    wire use_sec = fsk && pair_sec_reg;
    wire [COUNT_W-1:0] hi_cnt  = use_sec ? sht_reg : pht_reg;
    wire [COUNT_W-1:0] lo_cnt  = use_sec ? slt_reg : plt_reg;
    wire [COUNT_W-1:0] car_inc = COUNT_W'(car_cnt_reg + 1'b1);
    wire car_match = car_inc == (car_high_sel_reg ? hi_cnt : lo_cnt);
    wire car_wrap  = car_run && tick && car_match && !car_high_sel_reg;
    wire car_mod   = baseband_select ? 1'b1 : car_reg;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            car_cnt_reg      <= '0;
            car_high_sel_reg <= 1'b1;
            car_reg          <= 1'b1;
        end else if (!car_run || car_restart) begin
            car_cnt_reg      <= '0;
            car_high_sel_reg <= 1'b1;
            car_reg          <= 1'b1;
        end else if (tick) begin
            if (car_match) begin
                car_cnt_reg      <= '0;
                car_high_sel_reg <= !car_high_sel_reg;
                car_reg          <= !car_high_sel_reg;
            end else begin
                car_cnt_reg <= car_inc;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Modulator
    // ------------------------------------------------------------------------
    irc_mod_state_e   mst_reg;
    logic [MOD_W-1:0] mod_cnt_reg;
    logic [MOD_W-1:0] active_space_reg;
    logic             gate_reg;
    logic [2:0]       presc_reg;

    wire unit_tick  = tick && (presc_reg == 3'(UNIT_CLKS - 1));
    wire mod_tick   = (fsk && !baseband_select) ? car_wrap : unit_tick;
    wire underflow  = mod_tick && (mod_cnt_reg == '0);
    wire space_hit  = (mst_reg == IRC_SPACE) && (~mod_cnt_reg == active_space_reg);
    wire reload     = en && space_hit;
    wire mod_out    = gate_reg && car_mod;
    wire ir_next    = en ? mod_out : latch_reg;

    // Time mode restarts the carrier with the gate; shifting keeps phase
    assign car_restart = reload && !fsk;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mst_reg      <= IRC_MARK;
            mod_cnt_reg  <= `IRC_PERIOD_RST;
            active_space_reg     <= `IRC_PERIOD_RST;
            gate_reg     <= 1'b1;
            presc_reg    <= 3'h0;
            pair_sec_reg <= 1'b0;
        end else if (!en) begin
            mst_reg      <= IRC_MARK;
            mod_cnt_reg  <= mark_buf_reg;
            active_space_reg     <= space_buf_reg;
            gate_reg     <= 1'b1;
            presc_reg    <= 3'h0;
            pair_sec_reg <= 1'b0;
        end else begin
            if (tick) presc_reg <= 3'(presc_reg + 1'b1);
            if (reload) begin
                mst_reg      <= IRC_MARK;
                mod_cnt_reg  <= mark_buf_reg;
                active_space_reg     <= space_buf_reg;
                gate_reg     <= 1'b1;
                pair_sec_reg <= fsk ? !pair_sec_reg : 1'b0;
            end else begin
                if (mod_tick) mod_cnt_reg <= MOD_W'(mod_cnt_reg - 1'b1);
                if (mst_reg == IRC_MARK && underflow) mst_reg <= IRC_SPACE;
                // Closing on a high carrier would chop a pulse short
                if (mst_reg == IRC_SPACE && (!car_reg || baseband_select)) gate_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // End-of-cycle flag and output pin
    // ------------------------------------------------------------------------
    // A new reload wins over a simultaneous clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            eoc_reg       <= 1'b0;
            eoc_armed_reg <= 1'b0;
            IR_OUT        <= 1'b0;
        end else begin
            if (reload) eoc_reg <= 1'b1;
            else if (acc_per23 && eoc_armed_reg) eoc_reg <= 1'b0;
            if (rd_req && hit(a_addr, `IRC_OFF_CTRL)) eoc_armed_reg <= 1'b1;
            else if (acc_per23) eoc_armed_reg <= 1'b0;
            IR_OUT <= ir_next;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_reload;
        en && (mst_reg == IRC_SPACE) && (~mod_cnt_reg == active_space_reg);
    endsequence
    sequence s_car_step;
        car_run && !car_restart && tick && car_match;
    endsequence

    property p_car_idle;
        !car_run |=> (car_cnt_reg == '0) && car_high_sel_reg && car_reg;
    endproperty
    a_car_idle: assert property (p_car_idle)
        else $error("Idle carrier not held cleared");

    property p_car_fall;
        s_car_step ##0 car_high_sel_reg |=> !car_reg && !car_high_sel_reg
                                            && (car_cnt_reg == '0);
    endproperty
    a_car_fall: assert property (p_car_fall)
        else $error("High match did not drive carrier low");

    property p_car_rise;
        s_car_step ##0 !car_high_sel_reg |=> car_reg && car_high_sel_reg;
    endproperty
    a_car_rise: assert property (p_car_rise)
        else $error("Low match did not drive carrier high");

    property p_baseband_select_high;
        en && baseband_select |=> IR_OUT == $past(gate_reg);
    endproperty
    a_baseband_select_high: assert property (p_baseband_select_high)
        else $error("Baseband carrier not high");

    property p_time_primary;
        s_car_step ##0 !fsk |-> car_inc == (car_high_sel_reg ? pht_reg : plt_reg);
    endproperty
    a_time_primary: assert property (p_time_primary)
        else $error("Time mode used secondary pair");

    property p_reload;
        s_reload |=> (mod_cnt_reg == $past(mark_buf_reg)) && (active_space_reg == $past(space_buf_reg))
                     && eoc_reg && gate_reg && (mst_reg == IRC_MARK);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Reload did not copy buffers or set flag");

    property p_gate_close;
        $fell(gate_reg) |-> (!$past(car_reg) || $past(baseband_select)) && (mst_reg == IRC_SPACE);
    endproperty
    a_gate_close: assert property (p_gate_close)
        else $error("Gate closed while carrier high");

    property p_latch_fall;
        (pend_fall_reg && proc_clk_reg && !wr_pht && !wr_plt)
            |=> (latch_reg == $past(pend_val_reg)) && !proc_clk_reg;
    endproperty
    a_latch_fall: assert property (p_latch_fall)
        else $error("Falling-edge latch write missed");

    property p_latch_rise;
        (pend_rise_reg && !proc_clk_reg && !wr_pht && !wr_plt)
            |=> (latch_reg == $past(pend_val_reg)) && proc_clk_reg;
    endproperty
    a_latch_rise: assert property (p_latch_rise)
        else $error("Rising-edge latch write missed");

    property p_ir_out;
        1'b1 |=> IR_OUT == ($past(en) ? ($past(gate_reg) && ($past(car_reg) || $past(baseband_select)))
                                      : $past(latch_reg));
    endproperty
    a_ir_out: assert property (p_ir_out)
        else $error("Output pin source wrong");

    property p_mod_hold;
        !en |=> (mod_cnt_reg == $past(mark_buf_reg)) && (mst_reg == IRC_MARK) [*2];
    endproperty
    a_mod_hold: assert property (p_mod_hold)
        else $error("Modulator ran while disabled");

endmodule // irc_modulator

// ===== shared/irc_cfg.svh
// Offsets, field positions, reset values and timing counts of the infrared carrier modulator
`ifndef IRC_CFG_SVH
`define IRC_CFG_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IRC_OFF_PHT      8'h00
`define IRC_OFF_PLT      8'h04
`define IRC_OFF_SHT      8'h08
`define IRC_OFF_SLT      8'h0c
`define IRC_OFF_CTRL     8'h10
`define IRC_OFF_PER1     8'h14
`define IRC_OFF_PER2     8'h18
`define IRC_OFF_PER3     8'h1c
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IRC_EN_BIT       0
`define IRC_IE_BIT       1
`define IRC_MODE_BIT     2
`define IRC_BASEBAND_SELECT_BIT     3
`define IRC_CLOCK_HALVE_BIT     6
`define IRC_EOC_BIT      7
`define IRC_LATCH_BIT    7
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define IRC_CTRL_RST     8'h00
`define IRC_COUNT_RST    6'h01
`define IRC_PERIOD_RST   12'h000
`define IRC_CLK_NS       40
`define IRC_TIME_UNIT    8
`endif

// ===== shared/irc_pkg.sv
// Types shared by the infrared carrier modulator
package irc_pkg;
    typedef logic [31:0] irc_word_t;
    typedef logic [31:0] irc_addr_t;
    typedef enum logic {IRC_MARK, IRC_SPACE} irc_mod_state_e;
endpackage

// ===== testbench/irc_emitter_model.sv
// Emitter-side model: records run lengths seen on the infrared output
`timescale 1ns/1ps
// ------
// Emitter model
// ------
module irc_emitter_model (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Statistics clear
    input  wire logic        clr,
    // Infrared drive
    input  wire logic        IR_OUT,
    // Observations
    output int               hi_run,
    output int               lo_run,
    output logic [63:0]      hi_seen
);
    int   cnt;
    logic prev;
    logic skip;
    // Edge tracking survives a clear; the run cut by the clear is dropped, not counted
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt <= 1;
            prev <= 1'b0;
            skip <= 1'b1;
            hi_run <= 0;
            lo_run <= 0;
            hi_seen <= '0;
        end else begin
            if (clr) begin
                hi_run <= 0;
                lo_run <= 0;
                hi_seen <= '0;
            end else if (IR_OUT !== prev && !skip && prev) begin
                hi_run <= cnt;
                if (cnt < 64) begin
                    hi_seen[cnt] <= 1'b1;
                end
            end else if (IR_OUT !== prev && !skip) begin
                lo_run <= cnt;
            end
            if (clr) begin
                skip <= 1'b1;
            end else if (IR_OUT !== prev) begin
                skip <= 1'b0;
            end
            cnt <= (IR_OUT !== prev) ? 1 : cnt + 1;
            prev <= IR_OUT;
        end
    end
endmodule // irc_emitter_model

// ===== testbench/testbench.sv
// Self-checking bench for the infrared carrier modulator
`timescale 1ns/1ps
`include "irc_cfg.svh"
module testbench;
    import irc_pkg::*;
    // ------
    // Signals
    // ------
    logic        MCLK;
    logic        RST;
    logic        HSEL;
    irc_addr_t   HADDR;
    logic [1:0]  HTRANS;
    logic        HWRITE;
    logic [2:0]  HSIZE;
    irc_word_t   HWDATA;
    logic        HREADY;
    logic        HREADYOUT;
    logic        HRESP;
    irc_word_t   HRDATA;
    logic        IR_OUT;
    logic        clr;
    logic [63:0] hi_seen;
    logic [7:0]  h;
    logic [7:0]  l;
    logic [7:0]  m;
    logic [7:0]  s;
    int          hi_run;
    int          lo_run;
    int          miscompares;
    int          compares;
    int          seed;
    // Single slave, so its ready is the bus ready
    assign HREADY = HREADYOUT;
    irc_modulator dut (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .IR_OUT(IR_OUT));
    irc_emitter_model emitter (.MCLK(MCLK), .RST(RST), .clr(clr), .IR_OUT(IR_OUT),
        .hi_run(hi_run), .lo_run(lo_run), .hi_seen(hi_seen));
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // ------
    // Tasks
    // ------
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_near(input string nm, input int e, input int g, input int tol);
        compares++;
        if (g < e - tol || g > e + tol) begin
            miscompares++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic hold;
        int n;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            $display("[FAIL] hreadyout expected 1 seen %b", HREADYOUT);
            wrap_up();
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h000000, a};
        HWRITE <= wr;
        hold();
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= {24'h000000, d};
        hold();
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, {24'h000000, e}, HRDATA);
        chk("hresp", 32'h0, {31'h0, HRESP});
    endtask
    task automatic wait_out(input logic v);
        int n;
        n = 0;
        while (IR_OUT !== v && n < 8) begin
            @(posedge MCLK);
            n++;
        end
        chk("ir_out", {31'h0, v}, {31'h0, IR_OUT});
        if (IR_OUT !== v) begin
            wrap_up();
        end
    endtask
    task automatic run(input logic [7:0] c, input int n);
        xfer(1'b1, `IRC_OFF_CTRL, c);
        clr <= 1'b1;
        @(posedge MCLK);
        clr <= 1'b0;
        repeat (n) @(posedge MCLK);
    endtask
    // ------
    // Sequence
    // ------
    initial begin
        #(40 * 60000);
        miscompares++;
        $display("[FAIL] run_time expected done seen timeout");
        wrap_up();
    end
    initial begin
        seed = 40015;
        miscompares = 0;
        compares = 0;
        RST = 1'b1;
        HSEL = 1'b0;
        HADDR = '0;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HSIZE = 3'b010;
        HWDATA = '0;
        clr = 1'b0;
        repeat (3) @(posedge MCLK);
        RST <= 1'b0;
        repeat (2) @(posedge MCLK);
        rdchk("ctrl", `IRC_OFF_CTRL, 8'h00);
        rdchk("pht", `IRC_OFF_PHT, 8'h01);
        rdchk("per1", `IRC_OFF_PER1, 8'h00);
        xfer(1'b1, `IRC_OFF_PER1, 8'h5a);
        xfer(1'b1, `IRC_OFF_PER2, 8'hc3);
        xfer(1'b1, `IRC_OFF_PER3, 8'h7e);
        xfer(1'b1, 8'h20, 8'hff);
        rdchk("per1", `IRC_OFF_PER1, 8'h5a);
        rdchk("per2", `IRC_OFF_PER2, 8'hc3);
        rdchk("per3", `IRC_OFF_PER3, 8'h7e);
        rdchk("unmapped", 8'h20, 8'h00);
        $display("Register test done");
        h = 8'(1 + ($random(seed) & 15));
        l = 8'(1 + ($random(seed) & 15));
        xfer(1'b1, `IRC_OFF_PHT, 8'h80 | h);
        wait_out(1'b1);
        rdchk("plt", `IRC_OFF_PLT, 8'h81);
        xfer(1'b1, `IRC_OFF_PLT, l);
        wait_out(1'b0);
        rdchk("pht", `IRC_OFF_PHT, h);
        $display("Latch test done");
        // Secondary pair far longer than any primary run, so a wrong pair shows
        xfer(1'b1, `IRC_OFF_SHT, 8'h3f);
        xfer(1'b1, `IRC_OFF_SLT, 8'h3f);
        xfer(1'b1, `IRC_OFF_PER1, 8'h00);
        xfer(1'b1, `IRC_OFF_PER2, 8'hff);
        xfer(1'b1, `IRC_OFF_PER3, 8'h00);
        run(8'h01, 120);
        chk_near("carrier_high", h, hi_run, 0);
        chk_near("carrier_low", l, lo_run, 0);
        chk("pair", 32'h0, hi_seen[63]);
        xfer(1'b1, `IRC_OFF_CTRL, 8'h00);
        wait_out(1'b0);
        run(8'h41, 240);
        chk_near("halved_high", 2 * h, hi_run, 0);
        chk_near("halved_low", 2 * l, lo_run, 0);
        xfer(1'b1, `IRC_OFF_CTRL, 8'h00);
        $display("Carrier test done");
        m = 8'(2 + ($random(seed) & 7));
        s = 8'(1 + ($random(seed) & 7));
        xfer(1'b1, `IRC_OFF_PER2, m);
        xfer(1'b1, `IRC_OFF_PER3, s);
        run(8'h09, (m + 1 + s) * 24 + 40);
        chk_near("mark", (m + 1) * 8, hi_run, 1);
        chk_near("space", s * 8, lo_run, 1);
        rdchk("flag", `IRC_OFF_CTRL, 8'h89);
        xfer(1'b1, `IRC_OFF_CTRL, 8'h4e);
        rdchk("ctrl", `IRC_OFF_CTRL, 8'hce);
        xfer(1'b0, `IRC_OFF_PER2, 8'h00);
        rdchk("flag_clr", `IRC_OFF_CTRL, 8'h4e);
        $display("Baseband test done");
        xfer(1'b1, `IRC_OFF_PER3, 8'h00);
        run(8'h09, 300);
        chk_near("no_space", 0, lo_run, 0);
        chk("no_space_level", 32'h1, {31'h0, IR_OUT});
        xfer(1'b1, `IRC_OFF_CTRL, 8'h00);
        xfer(1'b1, `IRC_OFF_PHT, 8'h02);
        xfer(1'b1, `IRC_OFF_PLT, 8'h02);
        xfer(1'b1, `IRC_OFF_SHT, 8'h05);
        xfer(1'b1, `IRC_OFF_SLT, 8'h05);
        xfer(1'b1, `IRC_OFF_PER2, 8'h03);
        run(8'h05, 400);
        chk("primary_used", 32'h1, hi_seen[2]);
        chk("secondary_used", 32'h1, hi_seen[5]);
        $display("Frequency-shift test done");
        wrap_up();
    end
endmodule // testbench
